// ==== core/scft_defines.svh ====
`ifndef SCFT_DEFINES_SVH
`define SCFT_DEFINES_SVH

// ============================================================
// register offsets (7-bit configuration address)
`define SCFT_ADDR_LINES_LO     7'h01
`define SCFT_ADDR_LINES_HI     7'h02
`define SCFT_ADDR_EXP_0        7'h2a
`define SCFT_ADDR_EXP_1        7'h2b
`define SCFT_ADDR_EXP_2        7'h2c
`define SCFT_ADDR_MODE         7'h41
`define SCFT_ADDR_FRAMES_LO    7'h46
`define SCFT_ADDR_FRAMES_HI    7'h47
`define SCFT_ADDR_FOT_LEN      7'h49
`define SCFT_ADDR_OUTPUTS      7'h50
`define SCFT_ADDR_STATUS       7'h60
`define SCFT_ADDR_CLK_RANGE_A  7'h72
`define SCFT_ADDR_CLK_RANGE_B  7'h74

// ============================================================
// reset values
`define SCFT_RST_LINES         16'h0440
`define SCFT_RST_EXP           24'h000400
`define SCFT_RST_MODE          8'h00
`define SCFT_RST_FRAMES        16'h0001
`define SCFT_RST_FOT_LEN       8'h0a
`define SCFT_RST_OUTPUTS       8'h10
`define SCFT_RST_CLK_RANGE     8'h00

// ============================================================
// fields and timing
`define SCFT_MODE_EXT_BIT      0
`define SCFT_MODE_HDR_BIT      1
`define SCFT_ROW_CYCLES        24'd129
`define SCFT_MAX_OUTPUTS       8'h10
`define SCFT_FOT_CH_TERM       8'h20
`define SCFT_SPI_HDR_BITS      5'd8
`define SCFT_SPI_WORD_BITS     5'd16
`define SCFT_TMR_W             24

`endif

// ==== core/scft_pkg.sv ====
`include "scft_defines.svh"

package scft_pkg;
  // exposure engine
  typedef enum logic [1:0] {EX_IDLE, EX_RUN, EX_HOLD} scft_ex_state_t;
  // read-out engine
  typedef enum logic [1:0] {RD_IDLE, RD_FOT, RD_IMG} scft_rd_state_t;
  typedef logic [`SCFT_TMR_W-1:0] scft_count_t;
endpackage

// ==== core/scft_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "scft_defines.svh"

module scft_timer (
  // clock and resets
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic                  clear,
  // control
  input  wire logic                  load,
  input  wire scft_pkg::scft_count_t load_value,
  // status
  output logic                       busy,
  output logic                       done
);
  scft_pkg::scft_count_t cnt_reg, cnt_next;
  logic                  done_reg, done_next;

  // ============================================================
  // down counter: done marks the last counted cycle, so a phase that
  // leaves on done lasts exactly load_value cycles, not one more
  always_comb begin
    cnt_next = cnt_reg;
    if (clear) begin
      cnt_next = '0;
    end else if (load) begin
      cnt_next = load_value;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - `SCFT_TMR_W'(1);
    end
    done_next = !clear && (cnt_next == `SCFT_TMR_W'(1));
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg  <= '0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign busy = (cnt_reg != '0);
  assign done = done_reg;
endmodule

`default_nettype wire

// ==== core/scft_sensor.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "scft_defines.svh"

module scft_sensor (
  // master clock and power-on reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // control pins
  input  wire logic system_reset_n,
  input  wire logic frame_request,
  input  wire logic external_exposure_a,
  input  wire logic external_exposure_hdr,
  // configuration port
  input  wire logic spi_clk,
  input  wire logic spi_en,
  input  wire logic spi_in,
  output logic      spi_out,
  // frame timing status
  output logic      exposing,
  output logic      fot_active,
  output logic      image_active,
  output logic      frame_done
);
  // ============================================================
  // pin synchronisers: two flops before any logic reads a pin
  logic [5:0] pin_s1_reg, pin_s2_reg;
  logic       sclk_d_reg, sysn_d_reg;
  logic       sysn_s, req_s, exa_s, exh_s, sclk_s, sen_s, sin_s;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin_s1_reg <= 6'h00;
      pin_s2_reg <= 6'h00;
      sclk_d_reg <= 1'b0;
      sysn_d_reg <= 1'b0;
    end else begin
      pin_s1_reg <= {system_reset_n, frame_request, external_exposure_a,
                     external_exposure_hdr, spi_clk, spi_en};
      pin_s2_reg <= pin_s1_reg;
      sclk_d_reg <= sclk_s;
      sysn_d_reg <= sysn_s;
    end
  end

  // data pin sampled separately so it lines up with the port clock
  logic sin_s1_reg, sin_s2_reg;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sin_s1_reg <= 1'b0;
      sin_s2_reg <= 1'b0;
    end else begin
      sin_s1_reg <= spi_in;
      sin_s2_reg <= sin_s1_reg;
    end
  end

  assign {sysn_s, req_s, exa_s, exh_s, sclk_s, sen_s} = pin_s2_reg;
  assign sin_s = sin_s2_reg;

  // held low or just fallen: sequencer and registers go to defaults
  logic soft_rst;
  assign soft_rst = !sysn_s || (sysn_d_reg && !sysn_s);

  // ============================================================
  // configuration registers and serial port
  logic [15:0] lines_reg, lines_next;
  logic [23:0] exp_reg, exp_next;
  logic [7:0]  mode_reg, mode_next;
  logic [15:0] frames_reg, frames_next;
  logic [7:0]  fot_len_reg, fot_len_next;
  logic [7:0]  outputs_reg, outputs_next;
  logic [7:0]  clk_a_reg, clk_a_next;
  logic [7:0]  clk_b_reg, clk_b_next;
  logic [15:0] sh_reg, sh_next;
  logic [4:0]  bit_reg, bit_next;
  logic [7:0]  rdsh_reg, rdsh_next;
  logic        sout_reg, sout_next;
  logic [7:0]  status;
  logic        sclk_rise, sclk_fall;

  assign sclk_rise = sclk_s && !sclk_d_reg;
  assign sclk_fall = !sclk_s && sclk_d_reg;

  // register read decode; unmapped addresses read as zero
  function automatic logic [7:0] rd_decode(input logic [6:0] a);
    unique case (a)
      `SCFT_ADDR_LINES_LO:    rd_decode = lines_reg[7:0];
      `SCFT_ADDR_LINES_HI:    rd_decode = lines_reg[15:8];
      `SCFT_ADDR_EXP_0:       rd_decode = exp_reg[7:0];
      `SCFT_ADDR_EXP_1:       rd_decode = exp_reg[15:8];
      `SCFT_ADDR_EXP_2:       rd_decode = exp_reg[23:16];
      `SCFT_ADDR_MODE:        rd_decode = mode_reg;
      `SCFT_ADDR_FRAMES_LO:   rd_decode = frames_reg[7:0];
      `SCFT_ADDR_FRAMES_HI:   rd_decode = frames_reg[15:8];
      `SCFT_ADDR_FOT_LEN:     rd_decode = fot_len_reg;
      `SCFT_ADDR_OUTPUTS:     rd_decode = outputs_reg;
      `SCFT_ADDR_STATUS:      rd_decode = status;
      `SCFT_ADDR_CLK_RANGE_A: rd_decode = clk_a_reg;
      `SCFT_ADDR_CLK_RANGE_B: rd_decode = clk_b_reg;
      default:                rd_decode = 8'h00;
    endcase
  endfunction

  // 16-bit words: write flag, 7 address bits, 8 data bits, msb first
  always_comb begin
    lines_next   = lines_reg;
    exp_next     = exp_reg;
    mode_next    = mode_reg;
    frames_next  = frames_reg;
    fot_len_next = fot_len_reg;
    outputs_next = outputs_reg;
    clk_a_next   = clk_a_reg;
    clk_b_next   = clk_b_reg;
    sh_next      = sh_reg;
    bit_next     = bit_reg;
    rdsh_next    = rdsh_reg;
    sout_next    = sout_reg;
    if (!sen_s) begin
      bit_next = 5'd0;
    end else if (sclk_rise) begin
      sh_next  = {sh_reg[14:0], sin_s};
      bit_next = bit_reg + 5'd1;
      if (bit_next == `SCFT_SPI_HDR_BITS) begin
        rdsh_next = rd_decode(sh_next[6:0]);
      end
      if (bit_next == `SCFT_SPI_WORD_BITS) begin
        bit_next = 5'd0;  // burst: next word follows directly
        if (sh_next[15]) begin
          unique case (sh_next[14:8])
            `SCFT_ADDR_LINES_LO:    lines_next[7:0]   = sh_next[7:0];
            `SCFT_ADDR_LINES_HI:    lines_next[15:8]  = sh_next[7:0];
            `SCFT_ADDR_EXP_0:       exp_next[7:0]     = sh_next[7:0];
            `SCFT_ADDR_EXP_1:       exp_next[15:8]    = sh_next[7:0];
            `SCFT_ADDR_EXP_2:       exp_next[23:16]   = sh_next[7:0];
            `SCFT_ADDR_MODE:        mode_next         = sh_next[7:0];
            `SCFT_ADDR_FRAMES_LO:   frames_next[7:0]  = sh_next[7:0];
            `SCFT_ADDR_FRAMES_HI:   frames_next[15:8] = sh_next[7:0];
            `SCFT_ADDR_FOT_LEN:     fot_len_next      = sh_next[7:0];
            `SCFT_ADDR_OUTPUTS:     outputs_next      = sh_next[7:0];
            `SCFT_ADDR_CLK_RANGE_A: clk_a_next        = sh_next[7:0];
            `SCFT_ADDR_CLK_RANGE_B: clk_b_next        = sh_next[7:0];
            default: ;
          endcase
        end
      end
    end else if (sclk_fall && bit_reg >= `SCFT_SPI_HDR_BITS && !sh_reg[4'(bit_reg - 5'd1)]) begin
      // read: flag sits bit_reg-1 places up while the data bits shift in
      sout_next = rdsh_reg[7];
      rdsh_next = {rdsh_reg[6:0], 1'b0};
    end
    if (soft_rst) begin
      lines_next   = `SCFT_RST_LINES;
      exp_next     = `SCFT_RST_EXP;
      mode_next    = `SCFT_RST_MODE;
      frames_next  = `SCFT_RST_FRAMES;
      fot_len_next = `SCFT_RST_FOT_LEN;
      outputs_next = `SCFT_RST_OUTPUTS;
      clk_a_next   = `SCFT_RST_CLK_RANGE;
      clk_b_next   = `SCFT_RST_CLK_RANGE;
      bit_next     = 5'd0;
      sout_next    = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lines_reg   <= `SCFT_RST_LINES;
      exp_reg     <= `SCFT_RST_EXP;
      mode_reg    <= `SCFT_RST_MODE;
      frames_reg  <= `SCFT_RST_FRAMES;
      fot_len_reg <= `SCFT_RST_FOT_LEN;
      outputs_reg <= `SCFT_RST_OUTPUTS;
      clk_a_reg   <= `SCFT_RST_CLK_RANGE;
      clk_b_reg   <= `SCFT_RST_CLK_RANGE;
      sh_reg      <= 16'h0000;
      bit_reg     <= 5'd0;
      rdsh_reg    <= 8'h00;
      sout_reg    <= 1'b0;
    end else begin
      lines_reg   <= lines_next;
      exp_reg     <= exp_next;
      mode_reg    <= mode_next;
      frames_reg  <= frames_next;
      fot_len_reg <= fot_len_next;
      outputs_reg <= outputs_next;
      clk_a_reg   <= clk_a_next;
      clk_b_reg   <= clk_b_next;
      sh_reg      <= sh_next;
      bit_reg     <= bit_next;
      rdsh_reg    <= rdsh_next;
      sout_reg    <= sout_next;
    end
  end

  // ============================================================
  // read-out durations
  // output count taken as a power of two up to 16; other values round down, anything above 16 counts as 16, and zero counts as one
  logic [2:0]  osh;
  logic [23:0] fot_cycles, img_cycles;
  always_comb begin
    osh = 3'd4;
    if (outputs_reg < 8'h02) osh = 3'd0;
    else if (outputs_reg < 8'h04) osh = 3'd1;
    else if (outputs_reg < 8'h08) osh = 3'd2;
    else if (outputs_reg < `SCFT_MAX_OUTPUTS) osh = 3'd3;
    fot_cycles = 24'({16'h0000, fot_len_reg} + 24'(`SCFT_FOT_CH_TERM >> osh))
                 * `SCFT_ROW_CYCLES;
    img_cycles = 24'((`SCFT_ROW_CYCLES * {8'h00, lines_reg}) >> osh);
  end

  // ============================================================
  // exposure and read-out engines
  scft_pkg::scft_ex_state_t ex_reg, ex_next;
  scft_pkg::scft_rd_state_t rd_reg, rd_next;
  logic [15:0]           left_reg, left_next;
  logic                  exposing_reg, fot_reg, img_reg, fdone_reg, fdone_next;
  logic                  ex_load, rd_load, ex_busy, ex_done, rd_done, ext_on;
  scft_pkg::scft_count_t rd_value;

  assign ext_on = exa_s || (mode_reg[`SCFT_MODE_HDR_BIT] && exh_s);

  always_comb begin
    ex_next    = ex_reg;
    rd_next    = rd_reg;
    left_next  = left_reg;
    ex_load    = 1'b0;
    rd_load    = 1'b0;
    rd_value   = fot_cycles;
    fdone_next = 1'b0;
    unique case (ex_reg)
      scft_pkg::EX_IDLE: begin
        if (req_s && rd_reg == scft_pkg::RD_IDLE && frames_reg != 16'h0000) begin
          left_next = frames_reg;
          ex_next   = scft_pkg::EX_RUN;
          ex_load   = 1'b1;
        end
      end
      scft_pkg::EX_RUN: begin
        if (mode_reg[`SCFT_MODE_EXT_BIT] ? !ext_on : (ex_done || !ex_busy && !ex_load)) begin
          ex_next = scft_pkg::EX_HOLD;
        end
      end
      scft_pkg::EX_HOLD: begin
        // exposed frame waits for the previous read-out to finish
        if (rd_reg == scft_pkg::RD_IDLE || (rd_reg == scft_pkg::RD_IMG && rd_done)) begin
          rd_load   = 1'b1;
          left_next = left_reg - 16'h0001;
          ex_next   = (left_reg > 16'h0001) ? scft_pkg::EX_RUN : scft_pkg::EX_IDLE;
          ex_load   = (left_reg > 16'h0001);  // next exposure overlaps read-out
        end
      end
    endcase
    unique case (rd_reg)
      scft_pkg::RD_IDLE: if (rd_load) rd_next = scft_pkg::RD_FOT;
      scft_pkg::RD_FOT: begin
        if (rd_done) begin
          rd_next  = scft_pkg::RD_IMG;
          rd_load  = 1'b1;
          rd_value = img_cycles;
        end
      end
      scft_pkg::RD_IMG: begin
        if (rd_done) begin
          fdone_next = 1'b1;
          rd_next    = rd_load ? scft_pkg::RD_FOT : scft_pkg::RD_IDLE;
        end
      end
    endcase
    if (soft_rst) begin
      ex_next   = scft_pkg::EX_IDLE;
      rd_next   = scft_pkg::RD_IDLE;
      left_next = 16'h0000;
      rd_load   = 1'b0;
      ex_load   = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ex_reg       <= scft_pkg::EX_IDLE;
      rd_reg       <= scft_pkg::RD_IDLE;
      left_reg     <= 16'h0000;
      exposing_reg <= 1'b0;
      fot_reg      <= 1'b0;
      img_reg      <= 1'b0;
      fdone_reg    <= 1'b0;
    end else begin
      ex_reg       <= ex_next;
      rd_reg       <= rd_next;
      left_reg     <= left_next;
      exposing_reg <= (ex_next == scft_pkg::EX_RUN);
      fot_reg      <= (rd_next == scft_pkg::RD_FOT);
      img_reg      <= (rd_next == scft_pkg::RD_IMG);
      fdone_reg    <= fdone_next;
    end
  end

  scft_timer u_exp_timer (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .clear      (soft_rst),
    .load       (ex_load),
    .load_value (exp_reg),
    .busy       (ex_busy),
    .done       (ex_done)
  );

  scft_timer u_rd_timer (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .clear      (soft_rst),
    .load       (rd_load),
    .load_value (rd_value),
    .busy       (),
    .done       (rd_done)
  );

  assign status       = {4'h0, img_reg, fot_reg, exposing_reg, ex_reg != scft_pkg::EX_IDLE};
  assign spi_out      = sout_reg;
  assign exposing     = exposing_reg;
  assign fot_active   = fot_reg;
  assign image_active = img_reg;
  assign frame_done   = fdone_reg;
endmodule

`default_nettype wire

// ==== sim/scft_sensor_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// port checker for the sensor timing block
module scft_sensor_chk (
  // clock and resets
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic system_reset_n,
  // control pins
  input wire logic frame_request,
  input wire logic external_exposure_a,
  input wire logic external_exposure_hdr,
  // configuration port
  input wire logic spi_clk,
  input wire logic spi_en,
  input wire logic spi_in,
  input wire logic spi_out,
  // frame status
  input wire logic exposing,
  input wire logic fot_active,
  input wire logic image_active,
  input wire logic frame_done
);
  logic [15:0] fot_n_reg;
  logic [15:0] fot_n_next;
  logic [3:0]  quiet_reg;
  logic [3:0]  quiet_next;
  logic [2:0]  prev_reg;
  logic [2:0]  prev_next;

  // overhead length and cycles since a port or reset line fell
  always_comb begin
    prev_next = {spi_clk, spi_en, system_reset_n};
    fot_n_next = fot_active ? fot_n_reg + 16'h0001 : 16'h0000;
    quiet_next = ((prev_reg & ~prev_next) != 3'h0) ? 4'h0 : quiet_reg + {3'h0, quiet_reg != 4'hf};
  end

  // helper registers; prev starts low so reset release shows no fall
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fot_n_reg <= 16'h0000;
      quiet_reg <= 4'hf;
      prev_reg <= 3'h0;
    end else begin
      fot_n_reg <= fot_n_next;
      quiet_reg <= quiet_next;
      prev_reg <= prev_next;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ============================================================
  // sequences and properties
  sequence s_held_in_reset;
    !system_reset_n [*5];
  endsequence
  sequence s_ovh_ended;
    $fell(fot_active) && $past(system_reset_n, 3) && $past(system_reset_n, 4);
  endsequence
  property p_done_pulse;
    frame_done |=> !frame_done;
  endproperty
  property p_phase_excl;
    !(fot_active && image_active);
  endproperty
  property p_img_after_ovh;
    $rose(image_active) |-> $past(fot_active);
  endproperty
  property p_done_after_img;
    frame_done |-> $past(image_active);
  endproperty
  property p_sres_idle;
    s_held_in_reset |-> !exposing && !fot_active && !image_active && !frame_done;
  endproperty
  property p_no_start_in_reset;
    $rose(exposing) |-> $past(system_reset_n, 2) && $past(system_reset_n, 3);
  endproperty
  property p_ovh_units;
    s_ovh_ended |-> (fot_n_reg % 16'd129) == 16'h0000;
  endproperty
  property p_spi_out_timing;
    $changed(spi_out) |-> quiet_reg <= 4'h6;
  endproperty

  a_done_pulse:        assert property (p_done_pulse) else $error("frame done wider than one cycle");
  a_phase_excl:        assert property (p_phase_excl) else $error("overhead and image overlap");
  a_img_after_ovh:     assert property (p_img_after_ovh) else $error("image without overhead");
  a_done_after_img:    assert property (p_done_after_img) else $error("frame done without image");
  a_sres_idle:         assert property (p_sres_idle) else $error("activity while held in reset");
  a_no_start_in_reset: assert property (p_no_start_in_reset) else $error("exposure began in reset");
  a_ovh_units:         assert property (p_ovh_units) else $error("overhead not whole line units");
  a_spi_out_timing:    assert property (p_spi_out_timing) else $error("read data moved off clock fall");
endmodule

bind scft_sensor scft_sensor_chk i_chk (
  .ref_clk(ref_clk),
  .rst(rst),
  .system_reset_n(system_reset_n),
  .frame_request(frame_request),
  .external_exposure_a(external_exposure_a),
  .external_exposure_hdr(external_exposure_hdr),
  .spi_clk(spi_clk),
  .spi_en(spi_en),
  .spi_in(spi_in),
  .spi_out(spi_out),
  .exposing(exposing),
  .fot_active(fot_active),
  .image_active(image_active),
  .frame_done(frame_done)
);
`default_nettype wire

// ==== sim/scft_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// controller side of the configuration port
module scft_ctrl_model (
  // master clock
  input wire logic ref_clk,
  // configuration port
  output logic     spi_clk,
  output logic     spi_en,
  output logic     spi_in,
  input wire logic spi_out
);
  // port clock stands low between words
  initial begin
    spi_clk = 1'b0;
    spi_en = 1'b0;
    spi_in = 1'b0;
  end

  // half a port clock is six master clocks, above the four the sync needs
  task automatic half();
    repeat (6) @(posedge ref_clk);
    #1;
  endtask

  // one 16-bit word, msb first; en_val low sends a word that must be refused
  task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] data,
                      input logic en_val, output logic [7:0] q);
    logic [15:0] w;
    w = {wr, addr, data};
    q = 8'h00;
    @(posedge ref_clk);
    #1;
    spi_en = en_val;
    for (int i = 15; i >= 0; i--) begin
      spi_in = w[i];
      half();
      spi_clk = 1'b1;
      if (i < 8) begin
        q[i] = spi_out;
      end
      half();
      spi_clk = 1'b0;
    end
    half();
    spi_en = 1'b0;
    spi_in = ~spi_in;
  endtask
endmodule
`default_nettype wire

// ==== sim/scft_sensor_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// self-checking bench for the sensor timing block
module scft_sensor_tb_top;
  logic ref_clk;
  logic rst;
  logic system_reset_n;
  logic frame_request;
  logic ext_a;
  logic ext_hdr;
  wire  spi_clk;
  wire  spi_en;
  wire  spi_in;
  wire  spi_out;
  wire  exposing;
  wire  fot_active;
  wire  image_active;
  wire  frame_done;
  int   n_mismatch;
  int   n_tests;

  scft_sensor i_dut (.ref_clk(ref_clk), .rst(rst), .system_reset_n(system_reset_n),
    .frame_request(frame_request), .external_exposure_a(ext_a), .external_exposure_hdr(ext_hdr),
    .spi_clk(spi_clk), .spi_en(spi_en), .spi_in(spi_in), .spi_out(spi_out), .exposing(exposing),
    .fot_active(fot_active), .image_active(image_active), .frame_done(frame_done));
  scft_ctrl_model i_ctrl (.ref_clk(ref_clk), .spi_clk(spi_clk), .spi_en(spi_en), .spi_in(spi_in),
    .spi_out(spi_out));

  // 20 MHz master clock; the 25 ns half period gives a 50 ns cycle
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    i_ctrl.xfer(1'b1, a, d, 1'b1, q);
  endtask

  task automatic rd_chk(input string what, input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] q;
    i_ctrl.xfer(1'b0, a, 8'h00, 1'b1, q);
    chk(what, {24'h0, exp}, {24'h0, q});
  endtask

  // request held two clocks, beyond the one-clock minimum
  task automatic pulse_req();
    @(posedge ref_clk);
    #1;
    frame_request = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    frame_request = 1'b0;
  endtask

  task automatic t_defaults();
    rd_chk("overhead length", 7'h49, 8'h0a);
    rd_chk("range a", 7'h72, 8'h00);
    rd_chk("range b", 7'h74, 8'h00);
    rd_chk("unmapped", 7'h7f, 8'h00);
    wr(7'h72, 8'h5a);
    rd_chk("range a write", 7'h72, 8'h5a);
    $display("test defaults done");
  endtask

  // a word sent with the enable low leaves the register alone
  task automatic t_port_enable();
    logic [7:0] q;
    i_ctrl.xfer(1'b1, 7'h49, 8'h33, 1'b0, q);
    rd_chk("refused write", 7'h49, 8'h0a);
    wr(7'h49, 8'h02);
    // both line count bytes: the high byte defaults nonzero
    wr(7'h01, 8'h10);
    wr(7'h02, 8'h00);
    rd_chk("length write", 7'h49, 8'h02);
    $display("test port enable done");
  endtask

  // overhead 2, 16 lines; long exposure must govern the period
  task automatic run_frames(input logic [7:0] outs, input logic [23:0] expo, input logic [7:0] nfr);
    int fot_exp, img_exp, lo, t, fot_n, img_n, n_done, last, gap;
    logic fot_d;
    fot_exp = (2 + 32 / outs) * 129;
    img_exp = 129 * 16 / outs;
    lo = (expo > fot_exp + img_exp) ? int'(expo) : fot_exp + img_exp;
    wr(7'h50, outs);
    wr(7'h2a, expo[7:0]);
    wr(7'h2b, expo[15:8]);
    wr(7'h2c, expo[23:16]);
    wr(7'h46, nfr);
    pulse_req();
    fot_n = 0;
    img_n = 0;
    n_done = 0;
    last = -1;
    gap = lo;
    fot_d = 1'b0;
    for (t = 0; t < 30000 && n_done < nfr; t++) begin
      @(posedge ref_clk);
      #2;
      if (fot_active === 1'b1 && fot_d !== 1'b1) begin
        if (last >= 0) gap = t - last;
        last = t;
      end
      fot_d = fot_active;
      fot_n += int'(fot_active === 1'b1);
      img_n += int'(image_active === 1'b1);
      n_done += int'(frame_done === 1'b1);
    end
    if (t >= 30000) begin
      n_mismatch++;
      wrap_up();
    end
    chk("frames", nfr, n_done);
    chk("overhead cycles", nfr * fot_exp, fot_n);
    chk("image cycles", nfr * img_exp, img_n);
    chk("period in range", 1, gap >= lo && gap <= lo + 3);
    $display("test frames outputs %0d exposure %0d done", outs, expo);
  endtask

  // external exposure through each pin in turn, one frame each; the pin
  // stays high 40 clocks past the request and two sync stages add two
  task automatic t_ext_exposure();
    int n_exp, t;
    wr(7'h46, 8'h01);
    for (int m = 0; m < 2; m++) begin
      wr(7'h41, m[0] ? 8'h03 : 8'h01);
      if (m == 0) ext_a = 1'b1; else ext_hdr = 1'b1;
      pulse_req();
      n_exp = 0;
      for (t = 0; t < 3000 && frame_done !== 1'b1; t++) begin
        @(posedge ref_clk);
        #1;
        if (t == 39) begin
          ext_a = 1'b0;
          ext_hdr = 1'b0;
        end
        #1;
        n_exp += int'(exposing === 1'b1);
      end
      chk("external frame", 1, frame_done === 1'b1);
      chk("external exposure cycles", 42, n_exp);
    end
    wr(7'h41, 8'h00);
    $display("test external exposure done");
  endtask

  // reset in mid-frame idles the block and restores defaults
  task automatic t_sys_reset();
    wr(7'h46, 8'h03);
    pulse_req();
    repeat (40) @(posedge ref_clk);
    #1;
    system_reset_n = 1'b0;
    repeat (6) @(posedge ref_clk);
    #2;
    chk("idle in reset", 4'h0, {exposing, fot_active, image_active, frame_done});
    system_reset_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    rd_chk("length default", 7'h49, 8'h0a);
    rd_chk("frames default", 7'h46, 8'h01);
    rd_chk("range a default", 7'h72, 8'h00);
    $display("test system reset done");
  endtask

  // main sequence
  initial begin
    n_mismatch = 0;
    n_tests = 0;
    rst = 1'b1;
    system_reset_n = 1'b0;
    frame_request = 1'b0;
    ext_a = 1'b0;
    ext_hdr = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    system_reset_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    t_defaults();
    t_port_enable();
    for (int k = 0; k < 5; k++) begin
      run_frames(8'h10 >> k, 24'h000010, 8'h02);
    end
    run_frames(8'h08, 24'h000600, 8'h02);
    t_ext_exposure();
    t_sys_reset();
    wrap_up();
  end
endmodule
`default_nettype wire
